/* verif/adcwd_top_test.sv */
// Self-checking testbench for the converter control and window detector.
// Drives the register port and the analog core side from the bench.
`timescale 1ns/1ps
`default_nettype none
module adcwd_top_test;
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic conv_done = 1'b0;
  logic [adcwd_pkg::RES_W-1:0] conv_result = 10'h000;
  logic converter_on;
  logic conv_start;
  logic diff_mode;
  logic window_hit_flag;
  logic [adcwd_pkg::SEL_W-1:0] input_pos_sel;
  logic [adcwd_pkg::SEL_W-1:0] input_neg_sel;
  int fails = 0;
  int comparisons = 0;

  adcwd_top u_dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .conv_done(conv_done),
    .conv_result(conv_result),
    .converter_on(converter_on),
    .conv_start(conv_start),
    .diff_mode(diff_mode),
    .input_pos_sel(input_pos_sel),
    .input_neg_sel(input_neg_sel),
    .window_hit_flag(window_hit_flag)
  );

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  // Read data is registered and holds, so it is judged one cycle on
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  task automatic set_limits(input logic [9:0] g, input logic [9:0] l);
    wr(adcwd_pkg::ADDR_GT_HI, {6'h00, g[9:8]});
    wr(adcwd_pkg::ADDR_GT_LO, g[7:0]);
    wr(adcwd_pkg::ADDR_LT_HI, {6'h00, l[9:8]});
    wr(adcwd_pkg::ADDR_LT_LO, l[7:0]);
  endtask

  // Start clears any old flag, so each call judges only its own result
  task automatic conv(input logic [9:0] r, input logic hit);
    wr(adcwd_pkg::ADDR_CTRL, 8'h90);
    chk({15'h0000, conv_start}, 16'h0001);
    conv_done = 1'b1;
    conv_result = r;
    @(negedge ref_clk);
    conv_done = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({15'h0000, window_hit_flag}, {15'h0000, hit});
    rd_chk(adcwd_pkg::ADDR_RES_LO, r[7:0]);
    rd_chk(adcwd_pkg::ADDR_RES_HI, {6'h00, r[9:8]});
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    chk({15'h0000, converter_on}, 16'h0000);
    rd_chk(adcwd_pkg::ADDR_GT_HI, 8'hFF);
    rd_chk(adcwd_pkg::ADDR_GT_LO, 8'hFF);
    rd_chk(adcwd_pkg::ADDR_LT_HI, 8'h00);
    rd_chk(adcwd_pkg::ADDR_LT_LO, 8'h00);
    wr(adcwd_pkg::ADDR_GT_HI, 8'h5A);
    rd_chk(adcwd_pkg::ADDR_GT_HI, 8'h5A);
    $display("test_reset done");
  endtask

  task automatic test_outside();
    set_limits(10'h200, 10'h100);
    conv(10'h250, 1'b1);
    // A write with the flag bit at 1 neither clears nor sets it
    wr(adcwd_pkg::ADDR_CTRL, 8'hA0);
    chk({15'h0000, window_hit_flag}, 16'h0001);
    conv(10'h180, 1'b0);
    wr(adcwd_pkg::ADDR_CTRL, 8'hA0);
    chk({15'h0000, window_hit_flag}, 16'h0000);
    conv(10'h0FF, 1'b1);
    conv(10'h200, 1'b0);
    conv(10'h100, 1'b0);
    $display("test_outside done");
  endtask

  task automatic test_inside();
    set_limits(10'h100, 10'h300);
    conv(10'h200, 1'b1);
    conv(10'h100, 1'b0);
    conv(10'h300, 1'b0);
    conv(10'h050, 1'b0);
    $display("test_inside done");
  endtask

  task automatic test_select();
    logic [3:0] s;
    wr(adcwd_pkg::ADDR_CTRL, 8'h81);
    @(negedge ref_clk);
    chk({14'h0000, converter_on, diff_mode}, 16'h0003);
    for (int i = 0; i < 16; i++) begin
      s = i[3:0];
      wr(adcwd_pkg::ADDR_SEL, {~s, s});
      @(negedge ref_clk);
      chk({8'h00, input_neg_sel, input_pos_sel}, {8'h00, ~s, s});
    end
    wr(adcwd_pkg::ADDR_CTRL, 8'h80);
    @(negedge ref_clk);
    chk({15'h0000, diff_mode}, 16'h0000);
    $display("test_select done");
  endtask

  task automatic test_disable();
    // Busy reads back while a start waits, and disable drops it
    wr(adcwd_pkg::ADDR_CTRL, 8'h90);
    rd_chk(adcwd_pkg::ADDR_CTRL, 8'h90);
    wr(adcwd_pkg::ADDR_CTRL, 8'h00);
    rd_chk(adcwd_pkg::ADDR_CTRL, 8'h00);
    @(negedge ref_clk);
    chk({15'h0000, converter_on}, 16'h0000);
    conv_done = 1'b1;
    conv_result = 10'h200;
    @(negedge ref_clk);
    conv_done = 1'b0;
    repeat (2) @(negedge ref_clk);
    rd_chk(adcwd_pkg::ADDR_RES_LO, 8'h50);
    chk({15'h0000, window_hit_flag}, 16'h0000);
    $display("test_disable done");
  endtask

  // ==========================================================
  // Run and verdict
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    test_reset();
    test_outside();
    test_inside();
    test_select();
    test_disable();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* verilog/adcwd_pkg.sv */
// Package for the converter control and window detector block.
// Assumes an 8-bit special function register port on the system clock.
package adcwd_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL = 8'hE8;
  localparam logic [7:0] ADDR_SEL = 8'hBB;
  localparam logic [7:0] ADDR_RES_LO = 8'hBD;
  localparam logic [7:0] ADDR_RES_HI = 8'hBE;
  localparam logic [7:0] ADDR_GT_LO = 8'hC2;
  localparam logic [7:0] ADDR_GT_HI = 8'hC3;
  localparam logic [7:0] ADDR_LT_LO = 8'hC4;
  localparam logic [7:0] ADDR_LT_HI = 8'hC5;

  // ==========================================================
  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_WIN_BIT = 5;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_DIFF_BIT = 0;

  // ==========================================================
  // Input selector fields
  localparam int SEL_POS_LSB = 0;
  localparam int SEL_NEG_LSB = 4;
  localparam int SEL_W = 4;

  // ==========================================================
  // Widths and reset values
  localparam int RES_W = 10;
  localparam int RES_HI_W = 2;
  localparam logic [7:0] GT_HI_RST = 8'hFF;
  localparam logic [7:0] GT_LO_RST = 8'hFF;
  localparam logic [7:0] LT_HI_RST = 8'h00;
  localparam logic [7:0] LT_LO_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
endpackage

/* verilog/adcwd_top.sv */
// Control logic around a 10-bit converter: enable, input selection,
// result capture and window detection, all behind an SFR port.
// Assumes the analog core pulses conv_done with a valid result.
//
// Contract
// - The converter runs only while its enable bit is 1 and is shut down otherwise.
// - Single-ended and differential modes exist, with 16 software input selections.
// - The held 10-bit result is compared to the limits with no software help.
// - A detected window condition sets a flag in the control register.
// - Limits are an upper and a lower word, each split into high and low bytes.
// - The order of the two limit words picks inside or outside detection.
// - The upper limit high byte is read/write at 0xC3 and resets to all ones.
`timescale 1ns/1ps
`default_nettype none
module adcwd_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Analog core
  input wire logic conv_done,
  input wire logic [adcwd_pkg::RES_W-1:0] conv_result,
  output logic converter_on,
  output logic conv_start,
  output logic diff_mode,
  output logic [adcwd_pkg::SEL_W-1:0] input_pos_sel,
  output logic [adcwd_pkg::SEL_W-1:0] input_neg_sel,
  // Flag for polling or an interrupt controller
  output logic window_hit_flag
);
  logic [7:0] gt_hi;
  logic [7:0] gt_lo;
  logic [7:0] lt_hi;
  logic [7:0] lt_lo;
  logic [7:0] sel;
  logic [adcwd_pkg::RES_W-1:0] result;
  logic busy;
  logic eval;
  logic hit;
  logic wr_ctrl;
  logic start_req;
  logic done_ok;
  logic [adcwd_pkg::RES_W-1:0] upper_limit;
  logic [adcwd_pkg::RES_W-1:0] lower_limit;
  logic [7:0] next_rdata;

  assign wr_ctrl = sfr_wr && (sfr_addr == adcwd_pkg::ADDR_CTRL);
  assign start_req = wr_ctrl && sfr_wdata[adcwd_pkg::CTRL_BUSY_BIT]
                     && sfr_wdata[adcwd_pkg::CTRL_EN_BIT] && !busy;
  // A late done after disable is dropped: the core is already off
  assign done_ok = conv_done && converter_on;
  assign upper_limit = {gt_hi[adcwd_pkg::RES_HI_W-1:0], gt_lo};
  assign lower_limit = {lt_hi[adcwd_pkg::RES_HI_W-1:0], lt_lo};

  // ==========================================================
  // Control register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_on <= 1'b0;
      diff_mode <= 1'b0;
    end else if (wr_ctrl) begin
      converter_on <= sfr_wdata[adcwd_pkg::CTRL_EN_BIT];
      diff_mode <= sfr_wdata[adcwd_pkg::CTRL_DIFF_BIT];
    end
  end

  // ==========================================================
  // Input selector
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel <= adcwd_pkg::SEL_RST;
    end else if (sfr_wr && sfr_addr == adcwd_pkg::ADDR_SEL) begin
      sel <= sfr_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      input_pos_sel <= '0;
      input_neg_sel <= '0;
    end else begin
      input_pos_sel <= sel[adcwd_pkg::SEL_POS_LSB +: adcwd_pkg::SEL_W];
      input_neg_sel <= sel[adcwd_pkg::SEL_NEG_LSB +: adcwd_pkg::SEL_W];
    end
  end

  // ==========================================================
  // Limit words
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gt_hi <= adcwd_pkg::GT_HI_RST;
      gt_lo <= adcwd_pkg::GT_LO_RST;
      lt_hi <= adcwd_pkg::LT_HI_RST;
      lt_lo <= adcwd_pkg::LT_LO_RST;
    end else if (sfr_wr) begin
      if (sfr_addr == adcwd_pkg::ADDR_GT_HI) begin
        gt_hi <= sfr_wdata;
      end
      if (sfr_addr == adcwd_pkg::ADDR_GT_LO) begin
        gt_lo <= sfr_wdata;
      end
      if (sfr_addr == adcwd_pkg::ADDR_LT_HI) begin
        lt_hi <= sfr_wdata;
      end
      if (sfr_addr == adcwd_pkg::ADDR_LT_LO) begin
        lt_lo <= sfr_wdata;
      end
    end
  end

  // ==========================================================
  // Conversion start and busy
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_req;
    end
  end

  // Start first: its enable can land in the same write, while the old enable is still 0
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (start_req) begin
      busy <= 1'b1;
    end else if (!converter_on || done_ok
                 || (wr_ctrl && !sfr_wdata[adcwd_pkg::CTRL_EN_BIT])) begin
      busy <= 1'b0;
    end
  end

  // ==========================================================
  // Result capture and evaluation
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= '0;
    end else if (done_ok) begin
      result <= conv_result;
    end
  end

  // Compare one cycle later so the held result is what is judged
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      eval <= 1'b0;
    end else begin
      eval <= done_ok;
    end
  end

  adcwd_window_cmp u_cmp (
    .result(result),
    .upper_limit(upper_limit),
    .lower_limit(lower_limit),
    .hit(hit)
  );

  // Set wins over a clear written in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      window_hit_flag <= 1'b0;
    end else if (eval && hit) begin
      window_hit_flag <= 1'b1;
    end else if (wr_ctrl && !sfr_wdata[adcwd_pkg::CTRL_WIN_BIT]) begin
      window_hit_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Read path, one cycle latency; unmapped reads give zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (sfr_addr)
      adcwd_pkg::ADDR_CTRL: begin
        next_rdata[adcwd_pkg::CTRL_EN_BIT] = converter_on;
        next_rdata[adcwd_pkg::CTRL_WIN_BIT] = window_hit_flag;
        next_rdata[adcwd_pkg::CTRL_BUSY_BIT] = busy;
        next_rdata[adcwd_pkg::CTRL_DIFF_BIT] = diff_mode;
      end
      adcwd_pkg::ADDR_SEL: next_rdata = sel;
      adcwd_pkg::ADDR_RES_LO: next_rdata = result[7:0];
      adcwd_pkg::ADDR_RES_HI: begin
        next_rdata[adcwd_pkg::RES_HI_W-1:0] =
          result[adcwd_pkg::RES_W-1:8];
      end
      adcwd_pkg::ADDR_GT_HI: next_rdata = gt_hi;
      adcwd_pkg::ADDR_GT_LO: next_rdata = gt_lo;
      adcwd_pkg::ADDR_LT_HI: next_rdata = lt_hi;
      adcwd_pkg::ADDR_LT_LO: next_rdata = lt_lo;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= adcwd_pkg::RDATA_RST;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_done_eval;
    done_ok ##1 eval;
  endsequence

  sequence s_start;
    start_req ##1 (conv_start && busy);
  endsequence

  a_off_no_start: assert property (
    !converter_on |-> !conv_start && !busy)
    else $error("conversion activity while disabled");

  a_start_busy: assert property (
    s_start |=> !conv_start)
    else $error("start not a single pulse with busy");

  a_sel_follow: assert property (
    sfr_wr && sfr_addr == adcwd_pkg::ADDR_SEL
    |=> ##1 input_pos_sel == $past(sfr_wdata[3:0], 2)
    && input_neg_sel == $past(sfr_wdata[7:4], 2))
    else $error("input selection not applied");

  a_result_eval: assert property (
    s_done_eval |-> result == $past(conv_result, 1))
    else $error("held result not judged");

  a_flag_inside: assert property (
    done_ok && conv_result > upper_limit && conv_result < lower_limit
    && !sfr_wr |=> ##1 window_hit_flag)
    else $error("inside hit missed");

  a_flag_hold: assert property (
    window_hit_flag && !wr_ctrl |=> window_hit_flag)
    else $error("window flag dropped without clear");

  a_flag_outside: assert property (
    done_ok && lower_limit <= upper_limit && conv_result > upper_limit
    && !sfr_wr |=> ##1 window_hit_flag)
    else $error("outside hit missed");

  a_no_false_hit: assert property (
    eval && lower_limit > upper_limit && result <= upper_limit
    && !window_hit_flag |=> !window_hit_flag)
    else $error("flag set outside inside window");

  a_gt_hi_rw: assert property (
    sfr_wr && sfr_addr == adcwd_pkg::ADDR_GT_HI ##1 !sfr_wr ##1 sfr_rd
    && sfr_addr == adcwd_pkg::ADDR_GT_HI && !sfr_wr
    |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("upper limit high byte readback wrong");

  a_limit_word: assert property (
    sfr_wr && sfr_addr == adcwd_pkg::ADDR_LT_LO
    |=> lower_limit[7:0] == $past(sfr_wdata))
    else $error("lower limit low byte not stored");
endmodule
`default_nettype wire

/* verilog/adcwd_window_cmp.sv */
// Window comparison of one conversion result against two limit words.
// Purely combinational; the caller decides when the answer counts.
`timescale 1ns/1ps
`default_nettype none
module adcwd_window_cmp (
  // Operands
  input wire logic [adcwd_pkg::RES_W-1:0] result,
  input wire logic [adcwd_pkg::RES_W-1:0] upper_limit,
  input wire logic [adcwd_pkg::RES_W-1:0] lower_limit,
  // Answer
  output logic hit
);
  logic above;
  logic below;
  logic inside_mode;

  always_comb begin
    above = result > upper_limit;
    below = result < lower_limit;
    // Limit order picks inside or outside detection
    inside_mode = lower_limit > upper_limit;
    if (inside_mode) begin
      hit = above && below;
    end else begin
      hit = above || below;
    end
  end
endmodule
`default_nettype wire
